// ### logic/ptp_rx_message_qualifier.sv
`timescale 1ns/1ps
// Overview of operation
// - IP destination check enabled: verify IPv4 and IPv6 destination addresses.
// - MAC destination check enabled: verify destination MAC of UDP frames against enabled addresses.
// - raw Ethernet detect enabled: recognise messages directly in Ethernet frames.
// - IPv6 detect enabled: recognise messages in UDP over IPv6.
// - IPv4 detect enabled: recognise messages in UDP over IPv4.
// - domain match enabled: stamp only when domain equals programmed domain.
// - alternate-master check enabled: alternate master flag must be zero.
// - checksum bypass clear: bad UDP checksum blocks stamping and filtering.
// - FCS bypass clear: bad FCS blocks stamping and filtering.
// - version must equal programmed version; zero accepts any version.
// - stamp only when mask bit indexed by message type is set.
// - group one enable admits 224.0.1.129 and its MAC and IPv6 forms.
module ptp_rx_message_qualifier
	import ptp_rx_qual_pkg::*;
(
	// clock and reset
	input wire logic MCLK_I,
	input wire logic NRST_I,
	// wishbone slave
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [11:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	// receive byte stream
	input wire logic RX_VALID_I,
	input wire logic RX_SOP_I,
	input wire logic RX_EOP_I,
	input wire logic [7:0] RX_DATA_I,
	input wire logic RX_FCS_OK_I,
	input wire logic RX_UDP_CSUM_OK_I,
	// verdict
	output logic STAMP_O,
	output logic FILTER_CANDIDATE_O,
	output logic [3:0] MSG_TYPE_O
);
	import ptp_rx_qual_pkg::*;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [31:0] parse_cfg;
	logic [31:0] qual_cfg;
	logic [31:0] status;
	logic [15:0] stamp_count;
	logic [2:0] last_encap;

	ptp_rx_qual_regs u_regs (
		.clk_i(MCLK_I),
		.rst_n_i(NRST_I),
		.cyc_i(CYC_I),
		.stb_i(STB_I),
		.we_i(WE_I),
		.adr_i(ADR_I),
		.sel_i(SEL_I),
		.dat_i(DAT_I),
		.dat_o(DAT_O),
		.ack_o(ACK_O),
		.status_i(status),
		.parse_config_o(parse_cfg),
		.qualify_config_o(qual_cfg)
	);

	// settings are assumed static while the timing unit runs
	assign status = {stamp_count, 5'h00, last_encap, MSG_TYPE_O, 2'h0,
		FILTER_CANDIDATE_O, STAMP_O};

	// ------------------------------------------------------------
	// address decode helpers
	// ------------------------------------------------------------
	// expected group-one MAC byte, IPv4 or IPv6 flavour
	function automatic logic [7:0] group_mac(input logic [6:0] idx, input logic v6);
		logic [7:0] b;
		b = 8'h00;
		unique case (idx)
			7'd0: b = v6 ? 8'h33 : 8'h01;
			7'd1: b = v6 ? 8'h33 : 8'h00;
			7'd2: b = v6 ? 8'h00 : 8'h5E;
			7'd3: b = 8'h00;
			7'd4: b = 8'h01;
			7'd5: b = 8'h81;
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	// group-one IPv6 address byte; any scope nibble accepted
	function automatic logic ip6_byte_ok(input logic [6:0] rel, input logic [7:0] d);
		logic ok;
		ok = 1'b0;
		if (rel == 7'd0) begin
			ok = (d == 8'hFF);
		end else if (rel == 7'd1) begin
			ok = (d[7:4] == 4'h0);
		end else if (rel == 7'd14) begin
			ok = (d == 8'h01);
		end else if (rel == 7'd15) begin
			ok = (d == 8'h81);
		end else begin
			ok = (d == 8'h00);
		end
		return ok;
	endfunction

	function automatic logic [7:0] ip4_byte(input logic [6:0] rel);
		logic [7:0] b;
		b = 8'h00;
		unique case (rel)
			7'd0: b = 8'hE0;
			7'd1: b = 8'h00;
			7'd2: b = 8'h01;
			default: b = 8'h81;
		endcase
		return b;
	endfunction

	// ------------------------------------------------------------
	// byte position
	// ------------------------------------------------------------
	logic beat;
	logic [6:0] pos;
	logic [6:0] cnt;

	assign beat = RX_VALID_I;
	assign pos = RX_SOP_I ? 7'd0 : cnt;

	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			cnt <= 7'd0;
		end else if (beat) begin
			cnt <= (pos == COUNT_MAX) ? COUNT_MAX : pos + 7'd1;
		end
	end

	// ------------------------------------------------------------
	// encapsulation tracking
	// ------------------------------------------------------------
	encap_t encap;
	encap_t next_encap;
	logic [7:0] etype_hi;
	logic [15:0] etype;

	assign etype = {etype_hi, RX_DATA_I};

	always_comb begin
		next_encap = encap;
		if (RX_SOP_I) begin
			next_encap = ENC_WAIT;
		end
		unique case (encap)
			ENC_WAIT: begin
				if (!RX_SOP_I && pos == ETYPE_LO_POS) begin
					if (etype == ETYPE_PTP && parse_cfg[RAW_ETH_DETECT_BIT]) begin
						next_encap = ENC_RAW;
					end else if (etype == ETYPE_IPV4 && parse_cfg[UDP_V4_DETECT_BIT]) begin
						next_encap = ENC_V4;
					end else if (etype == ETYPE_IPV6 && parse_cfg[UDP_V6_DETECT_BIT]) begin
						next_encap = ENC_V6;
					end else begin
						next_encap = ENC_OTHER;
					end
				end
			end
			ENC_RAW, ENC_V4, ENC_V6, ENC_OTHER: begin
			end
		endcase
	end

	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			encap <= ENC_WAIT;
			etype_hi <= 8'h00;
		end else if (beat) begin
			encap <= next_encap;
			if (pos == ETYPE_HI_POS) begin
				etype_hi <= RX_DATA_I;
			end
		end
	end

	// ------------------------------------------------------------
	// header and address checks
	// ------------------------------------------------------------
	logic mac4_bad;
	logic mac6_bad;
	logic hdr_bad;
	logic ip_bad;
	logic [7:0] port_hi;
	logic port_ok;
	logic [6:0] base;
	logic [6:0] rel;
	logic in_ptp;

	always_comb begin
		base = V6_PTP_BASE;
		unique case (encap)
			ENC_RAW: base = L2_PTP_BASE;
			ENC_V4: base = V4_PTP_BASE;
			ENC_V6, ENC_WAIT, ENC_OTHER: base = V6_PTP_BASE;
		endcase
	end

	assign in_ptp = (encap == ENC_RAW || encap == ENC_V4 || encap == ENC_V6) && pos >= base;
	assign rel = pos - base;

	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			mac4_bad <= 1'b0;
			mac6_bad <= 1'b0;
			hdr_bad <= 1'b0;
			ip_bad <= 1'b0;
			port_hi <= 8'h00;
			port_ok <= 1'b0;
		end else if (beat) begin
			if (RX_SOP_I) begin
				mac4_bad <= RX_DATA_I != group_mac(7'd0, 1'b0);
				mac6_bad <= RX_DATA_I != group_mac(7'd0, 1'b1);
				hdr_bad <= 1'b0;
				ip_bad <= 1'b0;
				port_ok <= 1'b0;
			end else begin
				if (pos < 7'd6) begin
					mac4_bad <= mac4_bad | (RX_DATA_I != group_mac(pos, 1'b0));
					mac6_bad <= mac6_bad | (RX_DATA_I != group_mac(pos, 1'b1));
				end
				if (encap == ENC_V4) begin
					if ((pos == V4_VER_IHL_POS && RX_DATA_I != V4_VER_IHL) ||
						(pos == V4_PROTO_POS && RX_DATA_I != PROTO_UDP)) begin
						hdr_bad <= 1'b1;
					end
					if (pos >= V4_DST_POS && pos < V4_DST_POS + 7'd4 &&
						RX_DATA_I != ip4_byte(pos - V4_DST_POS)) begin
						ip_bad <= 1'b1;
					end
					if (pos == V4_PORT_POS) begin
						port_hi <= RX_DATA_I;
					end
					if (pos == V4_PORT_POS + 7'd1) begin
						port_ok <= {port_hi, RX_DATA_I} == PORT_EVENT ||
							{port_hi, RX_DATA_I} == PORT_GENERAL;
					end
				end
				if (encap == ENC_V6) begin
					if (pos == V6_NEXT_POS && RX_DATA_I != PROTO_UDP) begin
						hdr_bad <= 1'b1;
					end
					if (pos >= V6_DST_POS && pos < V6_DST_POS + 7'd16 &&
						!ip6_byte_ok(pos - V6_DST_POS, RX_DATA_I)) begin
						ip_bad <= 1'b1;
					end
					if (pos == V6_PORT_POS) begin
						port_hi <= RX_DATA_I;
					end
					if (pos == V6_PORT_POS + 7'd1) begin
						port_ok <= {port_hi, RX_DATA_I} == PORT_EVENT ||
							{port_hi, RX_DATA_I} == PORT_GENERAL;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// message header fields
	// ------------------------------------------------------------
	logic [3:0] msg_type;
	logic [3:0] msg_version;
	logic [7:0] msg_domain;
	logic alt_master;
	logic hdr_complete;

	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			msg_type <= 4'h0;
			msg_version <= 4'h0;
			msg_domain <= 8'h00;
			alt_master <= 1'b0;
			hdr_complete <= 1'b0;
		end else if (beat) begin
			if (RX_SOP_I) begin
				hdr_complete <= 1'b0;
			end else if (in_ptp) begin
				if (rel == PTP_TYPE_REL) begin
					msg_type <= RX_DATA_I[3:0];
				end
				if (rel == PTP_VERSION_REL) begin
					msg_version <= RX_DATA_I[3:0];
				end
				if (rel == PTP_DOMAIN_REL) begin
					msg_domain <= RX_DATA_I;
				end
				// short frames never reach the flags byte and never qualify
				if (rel == PTP_FLAGS_REL) begin
					alt_master <= RX_DATA_I[0];
					hdr_complete <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// end-of-frame verdict
	// ------------------------------------------------------------
	// evaluated one cycle after the last byte so every field flop has settled
	logic judge;
	logic fcs_ok;
	logic csum_ok;
	logic is_udp;
	logic detected;
	logic mac_ok;
	logic addr_ok;
	logic integrity_ok;
	logic fields_ok;
	logic [15:0] type_mask;

	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			judge <= 1'b0;
			fcs_ok <= 1'b0;
			csum_ok <= 1'b0;
		end else begin
			judge <= beat & RX_EOP_I;
			if (beat && RX_EOP_I) begin
				fcs_ok <= RX_FCS_OK_I;
				csum_ok <= RX_UDP_CSUM_OK_I;
			end
		end
	end

	assign is_udp = (encap == ENC_V4) || (encap == ENC_V6);
	assign detected = hdr_complete & (encap == ENC_RAW || (is_udp && !hdr_bad && port_ok));
	// raw Ethernet frames carry no group-one MAC, so the MAC check covers UDP only
	assign mac_ok = !parse_cfg[MAC_CHECK_BIT] || encap == ENC_RAW ||
		(parse_cfg[GROUP_ONE_BIT] &&
		(encap == ENC_V4 ? !mac4_bad : !mac6_bad));
	assign addr_ok = mac_ok && (!parse_cfg[IP_CHECK_BIT] || !is_udp ||
		(parse_cfg[GROUP_ONE_BIT] && !ip_bad));
	assign integrity_ok = (qual_cfg[FCS_BYPASS_BIT] || fcs_ok) &&
		(qual_cfg[UDP_CSUM_BYPASS_BIT] || !is_udp || csum_ok);
	assign type_mask = qual_cfg[TYPE_MASK_MSB:0];
	assign fields_ok = (!qual_cfg[DOMAIN_MATCH_BIT] ||
		msg_domain == qual_cfg[DOMAIN_MSB:DOMAIN_LSB]) &&
		(!qual_cfg[ALT_MASTER_BIT] || !alt_master) &&
		(qual_cfg[VERSION_MSB:VERSION_LSB] == VERSION_ANY ||
		msg_version == qual_cfg[VERSION_MSB:VERSION_LSB]) &&
		type_mask[msg_type];

	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			STAMP_O <= 1'b0;
			FILTER_CANDIDATE_O <= 1'b0;
			MSG_TYPE_O <= 4'h0;
			last_encap <= 3'h0;
			stamp_count <= 16'h0000;
		end else begin
			STAMP_O <= judge && detected && addr_ok && integrity_ok && fields_ok;
			FILTER_CANDIDATE_O <= judge && detected && addr_ok && integrity_ok;
			if (judge && detected) begin
				MSG_TYPE_O <= msg_type;
				last_encap <= {encap == ENC_V6, encap == ENC_V4, encap == ENC_RAW};
			end
			if (judge && detected && addr_ok && integrity_ok && fields_ok) begin
				stamp_count <= stamp_count + 16'h0001;
			end
		end
	end

endmodule // ptp_rx_message_qualifier

// ### logic/ptp_rx_qual_pkg.sv
package ptp_rx_qual_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [11:0] PARSE_CONFIG_OFFSET = 12'h158;
	localparam logic [11:0] QUALIFY_CONFIG_OFFSET = 12'h15C;
	localparam logic [11:0] STATUS_OFFSET = 12'h170;
	localparam logic [31:0] PARSE_CONFIG_RESET = 32'h0000101F;
	localparam logic [31:0] QUALIFY_CONFIG_RESET = 32'h00020000;
	localparam logic [31:0] PARSE_CONFIG_WMASK = 32'h0000101F;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int UDP_V4_DETECT_BIT = 0;
	localparam int UDP_V6_DETECT_BIT = 1;
	localparam int RAW_ETH_DETECT_BIT = 2;
	localparam int MAC_CHECK_BIT = 3;
	localparam int IP_CHECK_BIT = 4;
	localparam int GROUP_ONE_BIT = 12;
	localparam int DOMAIN_MSB = 31;
	localparam int DOMAIN_LSB = 24;
	localparam int DOMAIN_MATCH_BIT = 23;
	localparam int ALT_MASTER_BIT = 22;
	localparam int UDP_CSUM_BYPASS_BIT = 21;
	localparam int FCS_BYPASS_BIT = 20;
	localparam int VERSION_MSB = 19;
	localparam int VERSION_LSB = 16;
	localparam int TYPE_MASK_MSB = 15;

	// ------------------------------------------------------------
	// frame layout, byte offsets from first destination byte
	// ------------------------------------------------------------
	localparam logic [6:0] ETYPE_HI_POS = 7'd12;
	localparam logic [6:0] ETYPE_LO_POS = 7'd13;
	localparam logic [6:0] V4_VER_IHL_POS = 7'd14;
	localparam logic [6:0] V4_PROTO_POS = 7'd23;
	localparam logic [6:0] V4_DST_POS = 7'd30;
	localparam logic [6:0] V4_PORT_POS = 7'd36;
	localparam logic [6:0] V6_NEXT_POS = 7'd20;
	localparam logic [6:0] V6_DST_POS = 7'd38;
	localparam logic [6:0] V6_PORT_POS = 7'd56;
	localparam logic [6:0] L2_PTP_BASE = 7'd14;
	localparam logic [6:0] V4_PTP_BASE = 7'd42;
	localparam logic [6:0] V6_PTP_BASE = 7'd62;
	localparam logic [6:0] PTP_TYPE_REL = 7'd0;
	localparam logic [6:0] PTP_VERSION_REL = 7'd1;
	localparam logic [6:0] PTP_DOMAIN_REL = 7'd4;
	localparam logic [6:0] PTP_FLAGS_REL = 7'd6;
	localparam logic [6:0] COUNT_MAX = 7'h7F;

	// ------------------------------------------------------------
	// protocol constants
	// ------------------------------------------------------------
	localparam logic [15:0] ETYPE_PTP = 16'h88F7;
	localparam logic [15:0] ETYPE_IPV4 = 16'h0800;
	localparam logic [15:0] ETYPE_IPV6 = 16'h86DD;
	localparam logic [7:0] V4_VER_IHL = 8'h45;
	localparam logic [7:0] PROTO_UDP = 8'h11;
	localparam logic [15:0] PORT_EVENT = 16'h013F;
	localparam logic [15:0] PORT_GENERAL = 16'h0140;
	localparam logic [3:0] VERSION_ANY = 4'h0;

	typedef enum logic [4:0] {
		ENC_WAIT = 5'b00001,
		ENC_RAW = 5'b00010,
		ENC_V4 = 5'b00100,
		ENC_V6 = 5'b01000,
		ENC_OTHER = 5'b10000
	} encap_t;

endpackage

// ### logic/ptp_rx_qual_regs.sv
`timescale 1ns/1ps
module ptp_rx_qual_regs
	import ptp_rx_qual_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// configuration and state
	input wire logic [31:0] status_i,
	output logic [31:0] parse_config_o,
	output logic [31:0] qualify_config_o
);
	import ptp_rx_qual_pkg::*;

	logic req;
	logic [31:0] next_parse;
	logic [31:0] next_qualify;
	logic [31:0] rd_word;

	assign req = cyc_i & stb_i & ~ack_o;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// unwritable parse bits stay zero
	assign next_parse = merge(parse_config_o, dat_i, sel_i) & PARSE_CONFIG_WMASK;
	assign next_qualify = merge(qualify_config_o, dat_i, sel_i);

	always_comb begin
		rd_word = 32'h00000000;
		unique case (adr_i)
			PARSE_CONFIG_OFFSET: rd_word = parse_config_o;
			QUALIFY_CONFIG_OFFSET: rd_word = qualify_config_o;
			STATUS_OFFSET: rd_word = status_i;
			default: rd_word = 32'h00000000;
		endcase
	end

	// single-wait-state answer; unmapped reads zero, writes dropped
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= req;
			dat_o <= req ? rd_word : 32'h00000000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			parse_config_o <= PARSE_CONFIG_RESET;
			qualify_config_o <= QUALIFY_CONFIG_RESET;
		end else if (cyc_i && stb_i && we_i && ack_o) begin
			if (adr_i == PARSE_CONFIG_OFFSET) begin
				parse_config_o <= next_parse;
			end
			if (adr_i == QUALIFY_CONFIG_OFFSET) begin
				qualify_config_o <= next_qualify;
			end
		end
	end

endmodule // ptp_rx_qual_regs

// ### tb/ptp_rx_qual_checker_assertions.sv
`timescale 1ns/1ps
module ptp_rx_qual_checker
	import ptp_rx_qual_pkg::*;
(
	// clock and reset
	input wire logic MCLK_I,
	input wire logic NRST_I,
	// wishbone
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [11:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	input wire logic [31:0] DAT_O,
	input wire logic ACK_O,
	// stream and verdict
	input wire logic RX_VALID_I,
	input wire logic RX_EOP_I,
	input wire logic RX_FCS_OK_I,
	input wire logic STAMP_O,
	input wire logic FILTER_CANDIDATE_O
);
	logic fcs_bypass;
	logic [15:0] type_mask;

	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (!NRST_I);

	// shadow copy, settings only move between frames
	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			fcs_bypass <= 1'b0;
			type_mask <= 16'h0000;
		end else if (CYC_I && STB_I && WE_I && ACK_O && ADR_I == QUALIFY_CONFIG_OFFSET) begin
			if (SEL_I[2])
				fcs_bypass <= DAT_I[FCS_BYPASS_BIT];
			if (SEL_I[0])
				type_mask[7:0] <= DAT_I[7:0];
			if (SEL_I[1])
				type_mask[15:8] <= DAT_I[15:8];
		end
	end

	property p_ack_follows_req;
		CYC_I && STB_I && !ACK_O |=> ACK_O;
	endproperty
	a_ack_follows_req: assert property (p_ack_follows_req) else $error("no ack");
	property p_ack_pulse;
		ACK_O |=> !ACK_O;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_cause;
		ACK_O |-> $past(CYC_I && STB_I);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_dat_quiet;
		!ACK_O |-> DAT_O == 32'h00000000;
	endproperty
	a_dat_quiet: assert property (p_dat_quiet) else $error("read data outside ack");
	property p_stamp_pulse;
		STAMP_O |=> !STAMP_O;
	endproperty
	a_stamp_pulse: assert property (p_stamp_pulse) else $error("stamp too long");
	property p_stamp_cand;
		STAMP_O |-> FILTER_CANDIDATE_O;
	endproperty
	a_stamp_cand: assert property (p_stamp_cand) else $error("stamp not eligible");
	property p_cand_time;
		FILTER_CANDIDATE_O |-> $past(RX_VALID_I && RX_EOP_I, 2);
	endproperty
	a_cand_time: assert property (p_cand_time) else $error("verdict off eop");
	property p_fcs_gate;
		FILTER_CANDIDATE_O && !fcs_bypass |-> $past(RX_FCS_OK_I, 2);
	endproperty
	a_fcs_gate: assert property (p_fcs_gate) else $error("bad fcs passed");
	property p_mask_gate;
		STAMP_O |-> type_mask != 16'h0000;
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("stamp with empty mask");
endmodule // ptp_rx_qual_checker

// ### tb/ptp_rx_frame_src.sv
`timescale 1ns/1ps
module ptp_rx_frame_src (
	// clock
	input wire logic clk_i,
	// receive byte stream
	output logic valid_o,
	output logic sop_o,
	output logic eop_o,
	output logic [7:0] data_o,
	output logic fcs_ok_o,
	output logic csum_ok_o
);
	initial begin
		valid_o = 1'b0;
		sop_o = 1'b0;
		eop_o = 1'b0;
		data_o = 8'h00;
		fcs_ok_o = 1'b0;
		csum_ok_o = 1'b0;
	end

	// random stalls; idle beats carry junk, never the last byte
	task automatic send(input logic [7:0] b[$], input logic fcs, input logic csum);
		int i;
		logic v;
		i = 0;
		while (i < b.size()) begin
			@(posedge clk_i);
			v = ($urandom_range(5) != 0);
			valid_o <= v;
			sop_o <= v && i == 0;
			eop_o <= v && i == b.size() - 1;
			data_o <= v ? b[i] : ~data_o;
			fcs_ok_o <= v ? fcs : ~fcs;
			csum_ok_o <= v ? csum : ~csum;
			if (v)
				i++;
		end
		@(posedge clk_i);
		valid_o <= 1'b0;
		sop_o <= 1'b0;
		eop_o <= 1'b0;
		data_o <= ~data_o;
		fcs_ok_o <= ~fcs;
		csum_ok_o <= ~csum;
	endtask
endmodule // ptp_rx_frame_src

// ### tb/ptp_rx_message_qualifier_tb_top.sv
`timescale 1ns/1ps
module ptp_rx_message_qualifier_tb_top;
	import ptp_rx_qual_pkg::*;
	logic clk, rst_n, cyc, stb, we, ack, stamp, cand, rv, rs, re, rfcs, rcs;
	logic [11:0] adr;
	logic [3:0] sel, mtype;
	logic [31:0] wdat, rdat, pm, qm;
	logic [7:0] rd;
	logic [7:0] fb[$];
	logic [6:0] exp_q[$];
	logic [6:0] p1, p2;
	int bad_count, comparisons;

	ptp_rx_message_qualifier i_dut (.MCLK_I(clk), .NRST_I(rst_n), .CYC_I(cyc), .STB_I(stb),
		.WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
		.RX_VALID_I(rv), .RX_SOP_I(rs), .RX_EOP_I(re), .RX_DATA_I(rd), .RX_FCS_OK_I(rfcs),
		.RX_UDP_CSUM_OK_I(rcs), .STAMP_O(stamp), .FILTER_CANDIDATE_O(cand), .MSG_TYPE_O(mtype));
	ptp_rx_frame_src i_src (.clk_i(clk), .valid_o(rv), .sop_o(rs), .eop_o(re), .data_o(rd),
		.fcs_ok_o(rfcs), .csum_ok_o(rcs));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, ack, 1'b1);
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask

	// enc: 0 raw, 1 udp v4, 2 udp v6, 3 foreign ethertype
	task automatic mk(input int enc, input logic mok, iok, input logic [3:0] ty, ve,
		input logic [7:0] dm, input logic al);
		int b;
		fb = {};
		b = enc == 1 ? 42 : enc == 2 ? 62 : 14;
		for (int i = 0; i < b + 12; i++)
			fb.push_back(8'($urandom_range(255)));
		{fb[12], fb[13]} = enc == 0 ? ETYPE_PTP : enc == 1 ? ETYPE_IPV4 : enc == 2 ?
			ETYPE_IPV6 : 16'h0806;
		if (enc == 1) begin
			{fb[0], fb[1], fb[2], fb[3], fb[4], fb[5]} = {40'h01005E0001, mok ? 8'h81 : 8'h82};
			fb[14] = V4_VER_IHL;
			fb[23] = PROTO_UDP;
			{fb[30], fb[31], fb[32], fb[33]} = {24'hE00001, iok ? 8'h81 : 8'h82};
			{fb[36], fb[37]} = PORT_EVENT;
		end else if (enc == 2) begin
			{fb[0], fb[1], fb[2], fb[3], fb[4], fb[5]} = {40'h3333000001, mok ? 8'h81 : 8'h82};
			fb[20] = PROTO_UDP;
			for (int i = 38; i < 54; i++)
				fb[i] = 8'h00;
			{fb[38], fb[39], fb[52], fb[53]} = {24'hFF0E01, iok ? 8'h81 : 8'h82};
			{fb[56], fb[57]} = PORT_GENERAL;
		end
		fb[b] = {fb[b][7:4], ty};
		fb[b + 1] = {fb[b + 1][7:4], ve};
		fb[b + 4] = dm;
		fb[b + 6][0] = al;
	endtask

	function automatic logic [6:0] model(int enc, logic mok, iok, logic [3:0] ty, ve,
		logic [7:0] dm, logic al, fok, cok);
		logic det, aok, ok, cn, st;
		det = (enc == 0 && pm[2]) || (enc == 1 && pm[0]) || (enc == 2 && pm[1]);
		aok = enc == 0 || ((!pm[3] || (pm[12] && mok)) && (!pm[4] || (pm[12] && iok)));
		ok = (fok || qm[20]) && (enc == 0 || cok || qm[21]);
		cn = det && aok && ok;
		st = cn && (!qm[23] || dm == qm[31:24]) && (qm[19:16] == 4'h0 || ve == qm[19:16])
			&& (!qm[22] || !al) && qm[ty];
		return {ty, det, st, cn};
	endfunction

	always @(posedge clk) begin
		if (rst_n) begin
			chk({30'h0, stamp, cand}, {30'h0, p2[1:0]});
			if (p2[2])
				chk({28'h0, mtype}, {28'h0, p2[6:3]});
		end
		p2 <= p1;
		p1 <= (rv && re) ? exp_q.pop_front() : 7'h00;
	end

	task automatic end_sim();
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#240000;
		bad_count++;
		$display("ERROR t=%0t watchdog expired", $time);
		end_sim();
	end

	initial begin
		logic [31:0] q, w;
		int enc;
		logic mok, iok, al, fok, cok;
		logic [3:0] ty, ve;
		logic [6:0] e;
		logic [15:0] nst;
		logic [2:0] lenc;
		logic [3:0] lty;
		rst_n = 1'b0;
		{cyc, stb, we, adr, wdat, sel} = {15'h0, 32'h0, 4'hF};
		{bad_count, comparisons, p1, p2} = '0;
		{nst, lenc, lty} = '0;
		pm = PARSE_CONFIG_RESET;
		qm = QUALIFY_CONFIG_RESET;
		void'($urandom(32'h70B9));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk(PARSE_CONFIG_OFFSET, 32'h0000101F);
		rchk(QUALIFY_CONFIG_OFFSET, 32'h00020000);
		wb(1'b1, 12'h200, 32'hFFFFFFFF, q);
		rchk(12'h200, 32'h0);
		$display("test registers done");
		for (int k = 0; k < 300; k++) begin
			// settings move only while no frame is in flight
			if (k % 4 == 0 && k > 0) begin
				w = $urandom | $urandom;
				pm = w & PARSE_CONFIG_WMASK;
				qm = $urandom;
				qm[31:24] = {7'h0, qm[24]};
				ve = 4'($urandom_range(3));
				qm[19:16] = ve == 4'h1 ? 4'h0 : ve;
				qm[15:0] = k < 40 ? 16'h000F : 16'($urandom);
				wb(1'b1, PARSE_CONFIG_OFFSET, w, q);
				wb(1'b1, QUALIFY_CONFIG_OFFSET, qm, q);
				rchk(PARSE_CONFIG_OFFSET, pm);
				rchk(QUALIFY_CONFIG_OFFSET, qm);
			end
			enc = $urandom_range(3);
			{mok, iok, al} = {$urandom_range(7) != 0, $urandom_range(7) != 0, 1'($urandom)};
			{fok, cok} = {$urandom_range(7) != 0, $urandom_range(7) != 0};
			ty = $urandom_range(1) ? 4'($urandom_range(3)) : 4'($urandom);
			ve = $urandom_range(3) != 0 ? 4'h2 : 4'($urandom);
			mk(enc, mok, iok, ty, ve, 8'($urandom_range(1)), al);
			e = model(enc, mok, iok, ty, ve, fb[enc == 1 ? 46 : enc == 2 ? 66 : 18],
				al, fok, cok);
			exp_q.push_back(e);
			// running stamp count and last detected message for the status word
			nst += {15'h0, e[1]};
			if (e[2])
				{lenc, lty} = {3'(1 << enc), ty};
			i_src.send(fb, fok, cok);
		end
		repeat (4) @(posedge clk);
		rchk(STATUS_OFFSET, {nst, 5'h00, lenc, lty, 4'h0});
		$display("test frames done");
		end_sim();
	end
endmodule // ptp_rx_message_qualifier_tb_top

bind ptp_rx_message_qualifier ptp_rx_qual_checker i_chk (.MCLK_I(MCLK_I), .NRST_I(NRST_I),
	.CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
	.DAT_O(DAT_O), .ACK_O(ACK_O), .RX_VALID_I(RX_VALID_I), .RX_EOP_I(RX_EOP_I),
	.RX_FCS_OK_I(RX_FCS_OK_I), .STAMP_O(STAMP_O), .FILTER_CANDIDATE_O(FILTER_CANDIDATE_O));
